// *** hdl/cpc_core_ctrl.sv ***
// Clock throttling, interrupt entry/return, program counter and pointers.
// Assumes one decoded instruction per cmd_valid, aligned to core enables.
`timescale 1ns/10ps
`default_nettype none
`include "cpc_defs.svh"
module cpc_core_ctrl
    import cpc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  wire cpc_cmd_s    cmd,
    input  wire logic        irq_req,
    input  wire logic        flash_busy,
    input  wire logic [15:0] prog_rdata,
    input  wire logic        prog_rvalid,
    output logic             core_clk_en_ff,
    output logic [1:0]       clk_src_ff,
    output logic             pll_off_ff,
    output logic             osc_off_ff,
    output logic             sys_clk_off_ff,
    output logic             rt_oversample_ff,
    output logic             slow_osc_off_ff,
    output logic             irq_taken_ff,
    output logic [15:0]      pc_ff,
    output logic [11:0]      data_addr_ff,
    output logic             data_addr_vld_ff,
    output logic [23:0]      prog_addr_ff,
    output logic [15:0]      prog_wdata_ff,
    output logic             prog_rd_ff,
    output logic             prog_wr_ff,
    output logic             flash_wr_ff,
    output logic [7:0]       rd_data_ff
);
    localparam logic [119:0] DIV_TABLE = `CPC_DIV_TABLE;

    logic [7:0]  speed_ff;
    logic [7:0]  isr_speed_ff;
    logic [7:0]  speed_shadow_ff;
    logic [7:0]  extra_config_ff;
    logic [15:0] ret_addr_ff;
    logic [15:0] vector_ff;
    logic [15:0] stack_ptr_ff;
    logic [15:0] ind_ptr_ff;
    logic [15:0] dp_ptr_ff;
    logic [2:0]  page_ff;
    logic [2:0]  page_shadow_ff;
    logic        in_isr_ff;
    logic [2:0]  ptr_idx_ff;
    logic [23:0] ptr_ff [8];
    logic [7:0]  data_hi_ff;
    logic [7:0]  data_lo_ff;
    logic [7:0]  div_cnt_ff;
    logic        rd_pending_ff;

    logic        take_irq;
    logic        op_ok;
    logic [15:0] pc_inc;
    logic [8:0]  pcl_sum;
    logic [3:0]  div_code;
    logic [7:0]  div_val;
    logic        div_stop;
    logic [23:0] ptr_cur;
    logic [7:0]  extra_config_view;

    assign op_ok    = cmd_valid;
    assign pc_inc   = pc_ff + 16'h0001;
    assign ptr_cur  = ptr_ff[ptr_idx_ff];
    assign div_code = speed_ff[`CPC_SPD_DIV_HI:`CPC_SPD_DIV_LO];
    assign div_val  = DIV_TABLE[{div_code, 3'b000} +: 8];
    assign div_stop = (div_code == `CPC_DIV_OFF) ||
                      (speed_ff[`CPC_SPD_CLK_HI:`CPC_SPD_CLK_LO] == `CPC_CLK_OFF);
    assign extra_config_view = {extra_config_ff[7:1], flash_busy};

    // Hardware interrupt or the software one, both gated by the global enable
    always_comb begin
        take_irq = 1'b0;
        if (op_ok && !in_isr_ff && extra_config_ff[`CPC_XCF_GIE]) begin
            if (irq_req) begin
                take_irq = 1'b1;
            end else if (cmd.op == CPC_OP_INT && extra_config_ff[`CPC_XCF_INTEN]) begin
                take_irq = 1'b1;
            end
        end
    end

    always_comb begin
        pcl_sum = {1'b0, pc_ff[7:0]} + {1'b0, cmd.arg};
        if (cmd.op == CPC_OP_ADDC_PCL) begin
            pcl_sum = pcl_sum + {8'h00, cmd.carry_in};
        end
    end

    // Speed settings: only instruction, entry and return touch them
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_ff        <= `CPC_SPD_RESET;
            speed_shadow_ff <= `CPC_SPD_RESET;
        end else if (take_irq) begin
            speed_shadow_ff <= speed_ff;
            speed_ff        <= isr_speed_ff;
        end else if (op_ok && cmd.op == CPC_OP_RETI && cmd.opt) begin
            speed_ff <= speed_shadow_ff;
        end else if (op_ok && cmd.op == CPC_OP_SPEED) begin
            speed_ff <= cmd.arg;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            isr_speed_ff <= `CPC_SPD_RESET;
            extra_config_ff      <= `CPC_XCF_RESET;
        end else if (op_ok && !take_irq && cmd.op == CPC_OP_REG_WR) begin
            if (cmd.sel == CPC_REG_ISR_SPEED) begin
                isr_speed_ff <= cmd.arg;
            end else if (cmd.sel == CPC_REG_EXTRA_CONFIG) begin
                extra_config_ff <= cmd.arg & `CPC_XCF_WMASK;
            end
        end
    end

    // Clock tree controls decoded from the live speed and extra config settings
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_src_ff       <= 2'h0;
            pll_off_ff       <= 1'b0;
            osc_off_ff       <= 1'b0;
            sys_clk_off_ff   <= 1'b0;
            rt_oversample_ff <= 1'b0;
            slow_osc_off_ff  <= 1'b0;
        end else begin
            clk_src_ff       <= speed_ff[`CPC_SPD_CLK_HI:`CPC_SPD_CLK_LO];
            sys_clk_off_ff   <= speed_ff[`CPC_SPD_CLK_HI:`CPC_SPD_CLK_LO] == `CPC_CLK_OFF;
            pll_off_ff       <= speed_ff[`CPC_SPD_PLL];
            osc_off_ff       <= speed_ff[`CPC_SPD_OSC];
            rt_oversample_ff <= extra_config_ff[`CPC_XCF_RT_TIMER_OVERSAMPLE];
            slow_osc_off_ff  <= extra_config_ff[`CPC_XCF_SLOWOFF];
        end
    end

    // Reload divider; a new divide code takes effect at the next reload, the off code at once
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_ff     <= 8'h00;
            core_clk_en_ff <= 1'b0;
        end else if (div_stop) begin
            div_cnt_ff     <= 8'h00;
            core_clk_en_ff <= 1'b0;
        end else if (div_cnt_ff == 8'h00) begin
            div_cnt_ff     <= div_val - 8'h01;
            core_clk_en_ff <= 1'b1;
        end else begin
            div_cnt_ff     <= div_cnt_ff - 8'h01;
            core_clk_en_ff <= 1'b0;
        end
    end

    // Program counter, return address, vector and page bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_ff          <= 16'h0000;
            ret_addr_ff    <= 16'h0000;
            vector_ff      <= `CPC_VEC_RESET;
            page_ff        <= 3'h0;
            page_shadow_ff <= 3'h0;
            in_isr_ff      <= 1'b0;
            irq_taken_ff   <= 1'b0;
        end else begin
            irq_taken_ff <= take_irq;
            if (take_irq) begin
                ret_addr_ff    <= pc_ff;
                pc_ff          <= vector_ff;
                page_shadow_ff <= page_ff;
                page_ff        <= vector_ff[15:13];
                in_isr_ff      <= 1'b1;
            end else if (op_ok) begin
                case (cmd.op)
                    CPC_OP_RETI: begin
                        pc_ff     <= ret_addr_ff;
                        page_ff   <= page_shadow_ff;
                        in_isr_ff <= 1'b0;
                        if (cmd.opt) begin
                            vector_ff <= pc_inc;
                        end
                    end
                    CPC_OP_PAGE: begin
                        page_ff <= cmd.arg[2:0];
                        pc_ff   <= pc_inc;
                    end
                    CPC_OP_JUMP: begin
                        pc_ff <= {page_ff, cmd.target};
                    end
                    CPC_OP_ADD_PCL, CPC_OP_ADDC_PCL: begin
                        pc_ff <= {pc_ff[15:8] + {7'h00, pcl_sum[8]}, pcl_sum[7:0]};
                    end
                    CPC_OP_REG_WR: begin
                        if (cmd.sel == CPC_REG_PC_LO) begin
                            pc_ff <= {pc_ff[15:8], cmd.arg};
                        end else begin
                            pc_ff <= pc_inc;
                        end
                        if (cmd.sel == CPC_REG_RET_HI) begin
                            ret_addr_ff[15:8] <= cmd.arg;
                        end else if (cmd.sel == CPC_REG_RET_LO) begin
                            ret_addr_ff[7:0] <= cmd.arg;
                        end else if (cmd.sel == CPC_REG_VEC_HI) begin
                            vector_ff[15:8] <= cmd.arg;
                        end else if (cmd.sel == CPC_REG_VEC_LO) begin
                            vector_ff[7:0] <= cmd.arg;
                        end
                    end
                    default: begin
                        pc_ff <= pc_inc;
                    end
                endcase
            end
        end
    end

    // Data address generation and stack pointer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_ptr_ff     <= `CPC_SP_RESET;
            ind_ptr_ff       <= 16'h0000;
            dp_ptr_ff        <= 16'h0000;
            data_addr_ff     <= 12'h000;
            data_addr_vld_ff <= 1'b0;
        end else begin
            data_addr_vld_ff <= 1'b0;
            if (op_ok && !take_irq) begin
                case (cmd.op)
                    CPC_OP_PUSH: begin
                        data_addr_ff     <= stack_ptr_ff[11:0];
                        data_addr_vld_ff <= 1'b1;
                        stack_ptr_ff     <= stack_ptr_ff - 16'h0001;
                    end
                    CPC_OP_POP: begin
                        data_addr_ff     <= stack_ptr_ff[11:0] + 12'h001;
                        data_addr_vld_ff <= 1'b1;
                        stack_ptr_ff     <= stack_ptr_ff + 16'h0001;
                    end
                    CPC_OP_DIRECT: begin
                        data_addr_ff     <= {4'h0, cmd.arg};
                        data_addr_vld_ff <= 1'b1;
                    end
                    CPC_OP_IND: begin
                        data_addr_ff     <= ind_ptr_ff[11:0];
                        data_addr_vld_ff <= 1'b1;
                    end
                    CPC_OP_IND_DP: begin
                        data_addr_ff     <= dp_ptr_ff[11:0] + {5'h00, cmd.arg[6:0]};
                        data_addr_vld_ff <= 1'b1;
                    end
                    CPC_OP_IND_SP: begin
                        data_addr_ff     <= stack_ptr_ff[11:0] + {5'h00, cmd.arg[6:0]};
                        data_addr_vld_ff <= 1'b1;
                    end
                    CPC_OP_REG_WR: begin
                        if (cmd.sel == CPC_REG_SP_HI) begin
                            stack_ptr_ff[15:8] <= cmd.arg;
                        end else if (cmd.sel == CPC_REG_SP_LO) begin
                            stack_ptr_ff[7:0] <= cmd.arg;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Program memory pointers and word transfer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_idx_ff    <= 3'h0;
            ptr_ff        <= '{default: 24'h000000};
            data_hi_ff    <= 8'h00;
            data_lo_ff    <= 8'h00;
            prog_addr_ff  <= 24'h000000;
            prog_wdata_ff <= 16'h0000;
            prog_rd_ff    <= 1'b0;
            prog_wr_ff    <= 1'b0;
            flash_wr_ff   <= 1'b0;
            rd_pending_ff <= 1'b0;
        end else begin
            prog_rd_ff  <= 1'b0;
            prog_wr_ff  <= 1'b0;
            flash_wr_ff <= 1'b0;
            if (prog_rvalid && rd_pending_ff) begin
                data_hi_ff    <= prog_rdata[15:8];
                data_lo_ff    <= prog_rdata[7:0];
                rd_pending_ff <= 1'b0;
            end
            if (op_ok && !take_irq) begin
                case (cmd.op)
                    CPC_OP_IREAD, CPC_OP_IREADI: begin
                        prog_addr_ff  <= {ptr_cur[23:1], 1'b0};
                        prog_rd_ff    <= 1'b1;
                        rd_pending_ff <= 1'b1;
                        if (cmd.op == CPC_OP_IREADI) begin
                            ptr_ff[ptr_idx_ff] <= ptr_cur + `CPC_PTR_STEP;
                        end
                    end
                    CPC_OP_IWRITE, CPC_OP_IWRITEI: begin
                        prog_addr_ff  <= {ptr_cur[23:1], 1'b0};
                        prog_wdata_ff <= {data_hi_ff, data_lo_ff};
                        prog_wr_ff    <= 1'b1;
                        if (cmd.op == CPC_OP_IWRITEI) begin
                            ptr_ff[ptr_idx_ff] <= ptr_cur + `CPC_PTR_STEP;
                        end
                    end
                    CPC_OP_FWRITE: begin
                        prog_addr_ff  <= {ptr_cur[23:1], 1'b0};
                        prog_wdata_ff <= {data_hi_ff, data_lo_ff};
                        flash_wr_ff   <= extra_config_ff[`CPC_XCF_FWP];
                    end
                    CPC_OP_REG_WR: begin
                        if (cmd.sel == CPC_REG_PTR_IDX) begin
                            ptr_idx_ff <= cmd.arg[2:0];
                        end else if (cmd.sel == CPC_REG_PTR_UP) begin
                            ptr_ff[ptr_idx_ff][23:16] <= cmd.arg;
                        end else if (cmd.sel == CPC_REG_PTR_MID) begin
                            ptr_ff[ptr_idx_ff][15:8] <= cmd.arg;
                        end else if (cmd.sel == CPC_REG_PTR_LOW) begin
                            ptr_ff[ptr_idx_ff][7:0] <= cmd.arg;
                        end else if (cmd.sel == CPC_REG_DATA_HI) begin
                            data_hi_ff <= cmd.arg;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Register read-back, answered one cycle after the request
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= 8'h00;
        end else if (op_ok && !take_irq && cmd.op == CPC_OP_REG_RD) begin
            if (cmd.sel == CPC_REG_SPEED) begin
                rd_data_ff <= speed_ff;
            end else if (cmd.sel == CPC_REG_ISR_SPEED) begin
                rd_data_ff <= isr_speed_ff;
            end else if (cmd.sel == CPC_REG_EXTRA_CONFIG) begin
                rd_data_ff <= extra_config_view;
            end else if (cmd.sel == CPC_REG_PC_HI) begin
                rd_data_ff <= pc_ff[15:8];
            end else if (cmd.sel == CPC_REG_PC_LO) begin
                rd_data_ff <= pc_ff[7:0];
            end else if (cmd.sel == CPC_REG_RET_HI) begin
                rd_data_ff <= ret_addr_ff[15:8];
            end else if (cmd.sel == CPC_REG_RET_LO) begin
                rd_data_ff <= ret_addr_ff[7:0];
            end else if (cmd.sel == CPC_REG_VEC_HI) begin
                rd_data_ff <= vector_ff[15:8];
            end else if (cmd.sel == CPC_REG_VEC_LO) begin
                rd_data_ff <= vector_ff[7:0];
            end else if (cmd.sel == CPC_REG_SP_HI) begin
                rd_data_ff <= stack_ptr_ff[15:8];
            end else if (cmd.sel == CPC_REG_SP_LO) begin
                rd_data_ff <= stack_ptr_ff[7:0];
            end else if (cmd.sel == CPC_REG_PTR_IDX) begin
                rd_data_ff <= {5'h00, ptr_idx_ff};
            end else if (cmd.sel == CPC_REG_PTR_UP) begin
                rd_data_ff <= ptr_cur[23:16];
            end else if (cmd.sel == CPC_REG_PTR_MID) begin
                rd_data_ff <= ptr_cur[15:8];
            end else if (cmd.sel == CPC_REG_PTR_LOW) begin
                rd_data_ff <= ptr_cur[7:0];
            end else begin
                rd_data_ff <= data_hi_ff;
            end
        end
    end

    // Checks
    sequence entry_s;
        take_irq;
    endsequence

    sequence vec_load_s;
        pc_ff == $past(vector_ff) && page_ff == $past(vector_ff[15:13]);
    endsequence

    irq_entry_vec_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        entry_s |=> vec_load_s) else $error("Entry did not load vector and page");
    gie_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !extra_config_ff[`CPC_XCF_GIE] |=> !irq_taken_ff) else $error("Interrupt taken while disabled");
    isr_speed_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take_irq |=> speed_ff == $past(isr_speed_ff)) else $error("ISR speed not applied");
    speed_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(op_ok && (cmd.op == CPC_OP_SPEED || cmd.op == CPC_OP_RETI)) && !take_irq
        |=> $stable(speed_ff)) else $error("Speed changed without cause");
    flash_guard_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        flash_wr_ff |-> $past(extra_config_ff[`CPC_XCF_FWP])) else $error("Flash write while guarded");
    pcl_carry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op_ok && !take_irq && cmd.op == CPC_OP_ADD_PCL && pcl_sum[8]
        |=> pc_ff[15:8] == $past(pc_ff[15:8]) + 8'h01) else $error("High byte not bumped");
    push_dec_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op_ok && !take_irq && cmd.op == CPC_OP_PUSH
        |=> stack_ptr_ff == $past(stack_ptr_ff) - 16'h0001 && data_addr_ff == $past(stack_ptr_ff[11:0]))
        else $error("Push did not post-decrement");
    ptr_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        op_ok && !take_irq && cmd.op == CPC_OP_IREADI
        |=> ptr_ff[$past(ptr_idx_ff)] == $past(ptr_cur) + `CPC_PTR_STEP) else $error("Pointer not stepped");
    div_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        div_stop [*2] |-> !core_clk_en_ff) else $error("Core enable while stopped");
    div_one_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        div_code == 4'h0 && clk_src_ff != `CPC_CLK_OFF && core_clk_en_ff
        ##1 $stable(div_code) && !div_stop |=> core_clk_en_ff) else $error("Divide by one gap");
endmodule
`default_nettype wire

// *** hdl/cpc_defs.svh ***
// Constants of the CPU clock and program counter control block.
// Assumes inclusion by its bare name from the package and the design.
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH
`define CPC_SPD_PLL       7
`define CPC_SPD_OSC       6
`define CPC_SPD_CLK_HI    5
`define CPC_SPD_CLK_LO    4
`define CPC_SPD_DIV_HI    3
`define CPC_SPD_DIV_LO    0
`define CPC_SPD_RESET     8'h00
`define CPC_XCF_GIE       7
`define CPC_XCF_FWP       6
`define CPC_XCF_RT_TIMER_OVERSAMPLE     5
`define CPC_XCF_SLOWOFF   4
`define CPC_XCF_INTEN     3
`define CPC_XCF_BUSY      0
`define CPC_XCF_WMASK     8'hf8
`define CPC_XCF_RESET     8'h00
`define CPC_CLK_OFF       2'h3
`define CPC_DIV_OFF       4'hf
`define CPC_DIV_TABLE     {8'h80, 8'h40, 8'h30, 8'h20, 8'h18, 8'h10, 8'h0c, 8'h0a, \
                           8'h08, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01}
`define CPC_DIRECT_LO     12'h080
`define CPC_INDIRECT_LO   12'h100
`define CPC_PTR_STEP      24'h000002
`define CPC_VEC_RESET     16'h0000
`define CPC_SP_RESET      16'h0000
`endif

// *** hdl/cpc_pkg.sv ***
// Types shared by the clock and program counter control block.
// Assumes the constants header sits beside it.
`include "cpc_defs.svh"
package cpc_pkg;
    typedef enum logic [4:0] {
        CPC_OP_STEP, CPC_OP_SPEED, CPC_OP_REG_WR, CPC_OP_REG_RD, CPC_OP_INT,
        CPC_OP_RETI, CPC_OP_PAGE, CPC_OP_JUMP, CPC_OP_ADD_PCL, CPC_OP_ADDC_PCL,
        CPC_OP_PUSH, CPC_OP_POP, CPC_OP_DIRECT, CPC_OP_IND, CPC_OP_IND_DP,
        CPC_OP_IND_SP, CPC_OP_IREAD, CPC_OP_IREADI, CPC_OP_IWRITE, CPC_OP_IWRITEI,
        CPC_OP_FWRITE
    } cpc_op_e;
    typedef enum logic [3:0] {
        CPC_REG_SPEED, CPC_REG_ISR_SPEED, CPC_REG_EXTRA_CONFIG, CPC_REG_PC_HI, CPC_REG_PC_LO,
        CPC_REG_RET_HI, CPC_REG_RET_LO, CPC_REG_VEC_HI, CPC_REG_VEC_LO, CPC_REG_SP_HI,
        CPC_REG_SP_LO, CPC_REG_PTR_IDX, CPC_REG_PTR_UP, CPC_REG_PTR_MID,
        CPC_REG_PTR_LOW, CPC_REG_DATA_HI
    } cpc_reg_e;
    typedef struct packed {
        cpc_op_e   op;
        cpc_reg_e  sel;
        logic [7:0]  arg;
        logic [12:0] target;
        logic        opt;
        logic        carry_in;
    } cpc_cmd_s;
endpackage

// *** sim/tb_cpu_clock_and_pc_control.sv ***
// Bench for the clock and program counter control block.
// Assumes the package, header and core controller are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_clock_and_pc_control import cpc_pkg::*;;
    logic        ref_clk, rst_n, cmd_valid, irq_req, flash_busy, prog_rvalid;
    cpc_cmd_s    cmd;
    logic [15:0] prog_rdata, pc_ff;
    logic [23:0] prog_addr_ff;
    logic [7:0]  rd_data_ff;
    logic [1:0]  clk_src_ff;
    logic        core_clk_en_ff, sys_clk_off_ff, rt_oversample_ff, slow_osc_off_ff;
    logic        irq_taken_ff, prog_rd_ff, flash_wr_ff, prog_wr_ff;
    logic        pll_off_ff, osc_off_ff, data_addr_vld_ff;
    logic [11:0] data_addr_ff;
    logic [15:0] prog_wdata_ff;
    int          miscompares, n_tests, n;
    cpc_core_ctrl u_cpc_core_ctrl (.ref_clk, .rst_n, .cmd_valid, .cmd, .irq_req,
        .flash_busy, .prog_rdata, .prog_rvalid, .core_clk_en_ff, .clk_src_ff,
        .pll_off_ff, .osc_off_ff, .sys_clk_off_ff, .rt_oversample_ff,
        .slow_osc_off_ff, .irq_taken_ff, .pc_ff, .data_addr_ff,
        .data_addr_vld_ff, .prog_addr_ff, .prog_wdata_ff, .prog_rd_ff,
        .prog_wr_ff, .flash_wr_ff, .rd_data_ff);
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask
    // One instruction; effects are settled when this returns
    task automatic op(cpc_op_e o, cpc_reg_e s = CPC_REG_SPEED, logic [7:0] a = 8'h00,
                      logic [12:0] t = 13'h0000);
        @(posedge ref_clk);
        cmd <= '{o, s, a, t, 1'b1, 1'b0};
        cmd_valid <= 1'b1;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1;
    endtask
    // Clock tree outputs are decoded one edge after the setting changes
    task automatic settle;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic rd(cpc_reg_e s, logic [7:0] e);
        op(CPC_OP_REG_RD, s);
        @(posedge ref_clk);
        #1;
        chk(rd_data_ff, e);
    endtask
    task automatic count_en(int cyc, int e);
        n = 0;
        repeat (cyc) begin
            @(posedge ref_clk);
            #1;
            n += int'(core_clk_en_ff === 1'b1);
        end
        chk(24'(n), 24'(e));
    endtask
    task automatic irq_step(logic e);
        @(posedge ref_clk);
        irq_req <= 1'b1;
        op(CPC_OP_STEP);
        chk(irq_taken_ff, e);
        irq_req <= 1'b0;
    endtask
    task automatic t_speed;
        op(CPC_OP_SPEED, CPC_REG_SPEED, 8'h23);
        settle();
        chk(clk_src_ff, 2'h2);
        count_en(16, 4);
        op(CPC_OP_SPEED, CPC_REG_SPEED, 8'h0f);
        count_en(8, 0);
        op(CPC_OP_SPEED, CPC_REG_SPEED, 8'h30);
        settle();
        chk(sys_clk_off_ff, 1'b1);
        count_en(4, 0);
        op(CPC_OP_SPEED, CPC_REG_SPEED, 8'hc0);
        settle();
        chk(clk_src_ff, 2'h0);
        chk(pll_off_ff, 1'b1);
        chk(osc_off_ff, 1'b1);
        op(CPC_OP_SPEED, CPC_REG_SPEED, 8'h00);
        settle();
        chk(pll_off_ff, 1'b0);
        count_en(4, 4);
        op(CPC_OP_REG_WR, CPC_REG_SPEED, 8'hff);
        rd(CPC_REG_SPEED, 8'h00);
        $display("t_speed done");
    endtask
    task automatic t_extra_config;
        @(posedge ref_clk);
        flash_busy <= 1'b1;
        op(CPC_OP_REG_WR, CPC_REG_EXTRA_CONFIG, 8'hff);
        settle();
        chk(rt_oversample_ff, 1'b1);
        chk(slow_osc_off_ff, 1'b1);
        rd(CPC_REG_EXTRA_CONFIG, 8'hf9);
        flash_busy <= 1'b0;
        op(CPC_OP_REG_WR, CPC_REG_EXTRA_CONFIG, 8'h00);
        settle();
        chk(slow_osc_off_ff, 1'b0);
        op(CPC_OP_FWRITE);
        chk(flash_wr_ff, 1'b0);
        op(CPC_OP_REG_WR, CPC_REG_EXTRA_CONFIG, 8'h40);
        op(CPC_OP_FWRITE);
        chk(flash_wr_ff, 1'b1);
        $display("t_extra_config done");
    endtask
    task automatic t_ptr;
        op(CPC_OP_REG_WR, CPC_REG_PTR_IDX, 8'h03);
        op(CPC_OP_REG_WR, CPC_REG_PTR_UP, 8'h01);
        op(CPC_OP_REG_WR, CPC_REG_PTR_MID, 8'h23);
        op(CPC_OP_REG_WR, CPC_REG_PTR_LOW, 8'h45);
        op(CPC_OP_IREADI);
        chk(prog_rd_ff, 1'b1);
        chk(prog_addr_ff, 24'h012344);
        prog_rvalid <= 1'b1;
        prog_rdata <= 16'hbeef;
        @(posedge ref_clk);
        prog_rvalid <= 1'b0;
        rd(CPC_REG_DATA_HI, 8'hbe);
        rd(CPC_REG_PTR_LOW, 8'h47);
        op(CPC_OP_IWRITEI);
        chk(prog_wr_ff, 1'b1);
        chk(prog_wdata_ff, 16'hbeef);
        chk(prog_addr_ff, 24'h012346);
        rd(CPC_REG_PTR_LOW, 8'h49);
        op(CPC_OP_REG_WR, CPC_REG_PTR_IDX, 8'h00);
        rd(CPC_REG_PTR_LOW, 8'h00);
        $display("t_ptr done");
    endtask
    task automatic t_data;
        op(CPC_OP_REG_WR, CPC_REG_SP_LO, 8'h40);
        op(CPC_OP_PUSH);
        chk(data_addr_vld_ff, 1'b1);
        chk(data_addr_ff, 12'h040);
        rd(CPC_REG_SP_LO, 8'h3f);
        op(CPC_OP_POP);
        chk(data_addr_ff, 12'h040);
        rd(CPC_REG_SP_LO, 8'h40);
        op(CPC_OP_DIRECT, CPC_REG_SPEED, 8'h85);
        chk(data_addr_ff, 12'h085);
        op(CPC_OP_IND_SP, CPC_REG_SPEED, 8'hff);
        chk(data_addr_ff, 12'h0bf);
        $display("t_data done");
    endtask
    task automatic t_irq;
        rd(CPC_REG_VEC_LO, 8'h00);
        irq_step(1'b0);
        op(CPC_OP_REG_WR, CPC_REG_ISR_SPEED, 8'h01);
        op(CPC_OP_REG_WR, CPC_REG_EXTRA_CONFIG, 8'h80);
        op(CPC_OP_JUMP, CPC_REG_SPEED, 8'h00, 13'h0123);
        chk(pc_ff, 16'h0123);
        irq_step(1'b1);
        chk(pc_ff, 16'h0000);
        rd(CPC_REG_SPEED, 8'h01);
        rd(CPC_REG_RET_LO, 8'h23);
        op(CPC_OP_RETI);
        chk(pc_ff, 16'h0123);
        rd(CPC_REG_VEC_LO, 8'h03);
        op(CPC_OP_REG_WR, CPC_REG_PC_LO, 8'h80);
        chk(pc_ff, 16'h0180);
        op(CPC_OP_REG_WR, CPC_REG_PC_HI, 8'h55);
        chk(pc_ff[15:8], 8'h01);
        op(CPC_OP_ADD_PCL, CPC_REG_SPEED, 8'h80);
        chk(pc_ff, 16'h0201);
        op(CPC_OP_PAGE, CPC_REG_SPEED, 8'h05);
        op(CPC_OP_JUMP, CPC_REG_SPEED, 8'h00, 13'h0010);
        chk(pc_ff, 16'ha010);
        irq_step(1'b1);
        chk(pc_ff, 16'h0003);
        op(CPC_OP_JUMP, CPC_REG_SPEED, 8'h00, 13'h0020);
        chk(pc_ff, 16'h0020);
        op(CPC_OP_RETI);
        chk(pc_ff, 16'ha010);
        op(CPC_OP_JUMP, CPC_REG_SPEED, 8'h00, 13'h0030);
        chk(pc_ff, 16'ha030);
        rd(CPC_REG_SPEED, 8'h00);
        op(CPC_OP_INT);
        chk(irq_taken_ff, 1'b0);
        op(CPC_OP_REG_WR, CPC_REG_EXTRA_CONFIG, 8'h88);
        op(CPC_OP_INT);
        chk(irq_taken_ff, 1'b1);
        $display("t_irq done");
    endtask
    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Whole run needs under two hundred cycles
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end
    initial begin
        {rst_n, cmd_valid, irq_req, flash_busy, prog_rvalid} = '0;
        cmd = '0;
        prog_rdata = '0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_speed();
        t_extra_config();
        t_ptr();
        t_data();
        t_irq();
        complete_run();
    end
endmodule
`default_nettype wire
